// >>> logic/ccss_pkg.sv
// Constants and types for the CPU clock source select block
package ccss_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] CCSS_ADDR_RING_MODE  = 16'hFFA0; // Ring oscillator mode
  localparam logic [15:0] CCSS_ADDR_MAIN_MODE  = 16'hFFA1; // Main clock source mode
  localparam logic [15:0] CCSS_ADDR_MAIN_OSC   = 16'hFFA2; // Main oscillator control
  localparam logic [15:0] CCSS_ADDR_PROC_CLK   = 16'hFFFB; // Processor clock control

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CCSS_PROC_CRYSTAL_STOP = 7;  // Crystal stop bit
  localparam int CCSS_PROC_FEEDBACK_OFF = 6;  // Feedback resistor off
  localparam int CCSS_PROC_SUB_STATUS   = 5;  // Subsystem active status
  localparam int CCSS_PROC_SUB_SELECT   = 4;  // Subsystem select
  localparam int CCSS_PROC_FIXED_ZERO   = 3;  // Must be written 0
  localparam int CCSS_RING_STOP_POS     = 0;  // Ring stop bit
  localparam int CCSS_MAIN_STATUS_POS   = 1;  // Main source status
  localparam int CCSS_MAIN_SELECT_POS   = 0;  // Main source select
  localparam int CCSS_OSC_CRYSTAL_STOP  = 7;  // Crystal stop from ring

  // ----------------------------------------------------------------
  // Reset values and divider codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CCSS_REG_RESET     = 8'h00; // All four registers
  localparam logic [2:0] CCSS_DIV_MAX_CODE  = 3'h4;  // Main clock divided by 16
  localparam logic [2:0] CCSS_DIV_SUB_CODE  = 3'h0;  // Only code legal with subsystem

  // ----------------------------------------------------------------
  // Timing: clock gated off around a source or divider switch
  // ----------------------------------------------------------------
  localparam int CCSS_CLK_PERIOD_NS  = 40;   // 25 MHz
  localparam int CCSS_GATE_TIME_NS   = 200;  // Least quiet time per switch phase
  localparam int CCSS_GATE_CYCLES    =
    (CCSS_GATE_TIME_NS + CCSS_CLK_PERIOD_NS - 1) / CCSS_CLK_PERIOD_NS;
  localparam logic [3:0] CCSS_GATE_LAST = 4'(CCSS_GATE_CYCLES - 1); // Counter end

  // ----------------------------------------------------------------
  // Switch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCSS_IDLE,
    CCSS_GATE_OFF,
    CCSS_GATE_ON
  } ccss_state_t;

endpackage

// >>> logic/ccss_clock_select.sv
// CPU clock source and divider selection with oscillator stop control
`timescale 1ns/1ps
// Behaviour
// (RQ1) Reset clears processor clock control to zero
// (RQ2) Bit 7 set stops the crystal
// (RQ3) Bit 6 set disconnects subsystem feedback resistor
// (RQ4) Software sets bit 6 only without subsystem
// (RQ5) Bit 5 reads one while on subsystem
// (RQ6) Divider codes select div1..16 or subsystem/2
// (RQ7) Software always writes zero to bit 3
// (RQ8) Leave subsystem only with main status/select high
// (RQ9) On ring clock, processor stop bit ignored
// (RQ10) On subsystem, oscillator control stop bit ignored
// (RQ11) Software avoids stop instruction on ring/subsystem
// (RQ12) Ring mode bit 0 stops ring oscillator
// (RQ13) Ring stop needs stoppable option, non-ring source
// (RQ14) Software checks main status before ring stop
// (RQ15) Main select: 0 ring, 1 crystal
// (RQ16) Main status reports actual main source
// (RQ17) Software stops peripherals before crystal-to-ring switch
// (RQ18) Oscillator control stop acts only on ring
// (RQ19) Software checks main status before oscillator stop
// (RQ20) Setting a crystal stop bit clears stabilisation status
// (RQ21) Glitch-free switch; status follows actual source
module ccss_clock_select (
  input  wire logic        clk,                  // 25 MHz system clock
  input  wire logic        rst_n,                // Synchronous reset, active low
  input  wire logic [15:0] sfr_addr,             // Register address
  input  wire logic [7:0]  sfr_wdata,            // Write data
  input  wire logic        sfr_we,               // Write strobe
  input  wire logic        sfr_re,               // Read strobe
  input  wire logic        ring_stoppable_pin,   // Option strap, asynchronous
  output logic      [7:0]  sfr_rdata,            // Read data, one cycle after strobe
  output logic             crystal_enable,       // Crystal oscillator runs
  output logic             ring_enable,          // Ring oscillator runs
  output logic             feedback_resistor_on, // Subsystem feedback resistor used
  output logic             cpu_clk_gate,         // CPU clock passes when high
  output logic             cpu_src_sub,          // Active source is subsystem
  output logic             cpu_src_xtal,         // Active main source is crystal
  output logic      [2:0]  cpu_div_code,         // Active divider code
  output logic             stab_clear            // Pulse: clear stabilisation status
);
  import ccss_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic       crystal_stop_bit;        // Processor clock bit 7
  logic       feedback_resistor_off;   // Processor clock bit 6
  logic       subsystem_select;        // Processor clock bit 4
  logic [2:0] divider_code;            // Processor clock bits 2..0
  logic       ring_stop_bit;           // Ring mode bit 0
  logic       main_source_select;      // Main mode bit 0
  logic       crystal_stop_from_ring;  // Oscillator control bit 7
  logic       subsystem_active_status; // Read-only, follows active source
  logic       main_source_status;      // Read-only, follows active source
  logic       strap_meta;              // Strap synchroniser, first stage
  logic       ring_stoppable;          // Strap synchroniser, second stage
  ccss_state_t state;                  // Switch sequencer
  logic [3:0]  gate_cnt;               // Cycles in current phase

  logic       wr_proc;                 // Write to processor clock control
  logic       wr_ring;                 // Write to ring mode
  logic       wr_main;                 // Write to main mode
  logic       wr_osc;                  // Write to oscillator control
  logic       req_legal;               // Requested selection is allowed
  logic       req_differs;             // Requested selection not yet active

  assign wr_proc = sfr_we && (sfr_addr == CCSS_ADDR_PROC_CLK);
  assign wr_ring = sfr_we && (sfr_addr == CCSS_ADDR_RING_MODE);
  assign wr_main = sfr_we && (sfr_addr == CCSS_ADDR_MAIN_MODE);
  assign wr_osc  = sfr_we && (sfr_addr == CCSS_ADDR_MAIN_OSC);

  // Subsystem only with code 000, main clock up to code 100
  assign req_legal   = subsystem_select ? (divider_code == CCSS_DIV_SUB_CODE)
                                        : (divider_code <= CCSS_DIV_MAX_CODE); // [RQ6]
  assign req_differs = (subsystem_select != cpu_src_sub) ||
                       (main_source_select != cpu_src_xtal) ||
                       (divider_code != cpu_div_code);

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  // Two flops before the option strap is used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_meta     <= 1'b0;
      ring_stoppable <= 1'b0;
    end else begin
      strap_meta     <= ring_stoppable_pin;
      ring_stoppable <= strap_meta;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Processor clock control; bit 3 and bit 5 are not stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crystal_stop_bit      <= CCSS_REG_RESET[CCSS_PROC_CRYSTAL_STOP]; // [RQ1]
      feedback_resistor_off <= CCSS_REG_RESET[CCSS_PROC_FEEDBACK_OFF]; // [RQ1]
      subsystem_select      <= CCSS_REG_RESET[CCSS_PROC_SUB_SELECT];   // [RQ1]
      divider_code          <= CCSS_REG_RESET[2:0];                    // [RQ1]
    end else if (wr_proc) begin
      crystal_stop_bit      <= sfr_wdata[CCSS_PROC_CRYSTAL_STOP];
      feedback_resistor_off <= sfr_wdata[CCSS_PROC_FEEDBACK_OFF];
      subsystem_select      <= sfr_wdata[CCSS_PROC_SUB_SELECT];
      divider_code          <= sfr_wdata[2:0];
    end
  end

  // Ring mode, main mode and oscillator control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ring_stop_bit          <= CCSS_REG_RESET[CCSS_RING_STOP_POS];
      main_source_select     <= CCSS_REG_RESET[CCSS_MAIN_SELECT_POS];
      crystal_stop_from_ring <= CCSS_REG_RESET[CCSS_OSC_CRYSTAL_STOP];
    end else begin
      if (wr_ring) begin
        ring_stop_bit <= sfr_wdata[CCSS_RING_STOP_POS];
      end
      if (wr_main) begin
        main_source_select <= sfr_wdata[CCSS_MAIN_SELECT_POS];
      end
      if (wr_osc) begin
        crystal_stop_from_ring <= sfr_wdata[CCSS_OSC_CRYSTAL_STOP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Registered read data, zero for unmapped addresses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_re) begin
      unique case (sfr_addr)
        CCSS_ADDR_PROC_CLK:  sfr_rdata <= {crystal_stop_bit, feedback_resistor_off,
                                           subsystem_active_status, subsystem_select,
                                           1'b0, divider_code};                 // [RQ5]
        CCSS_ADDR_RING_MODE: sfr_rdata <= {7'h00, ring_stop_bit};
        CCSS_ADDR_MAIN_MODE: sfr_rdata <= {6'h00, main_source_status,
                                           main_source_select};                 // [RQ16]
        CCSS_ADDR_MAIN_OSC:  sfr_rdata <= {crystal_stop_from_ring, 7'h00};
        default:             sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free switch sequencer
  // ----------------------------------------------------------------
  // Gate off, hold quiet, change source, hold quiet, gate on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= CCSS_IDLE;
      gate_cnt     <= 4'h0;
      cpu_clk_gate <= 1'b1;
      cpu_src_sub  <= 1'b0;
      cpu_src_xtal <= 1'b0;
      cpu_div_code <= 3'h0;
    end else begin
      unique case (state)
        CCSS_IDLE: begin
          if (req_legal && req_differs) begin
            state        <= CCSS_GATE_OFF;
            gate_cnt     <= 4'h0;
            cpu_clk_gate <= 1'b0;                                               // [RQ21]
          end
        end
        CCSS_GATE_OFF: begin
          if (gate_cnt == CCSS_GATE_LAST) begin
            state        <= CCSS_GATE_ON;
            gate_cnt     <= 4'h0;
            cpu_src_sub  <= subsystem_select;                                   // [RQ6]
            cpu_src_xtal <= main_source_select;                                 // [RQ15]
            cpu_div_code <= divider_code;                                       // [RQ6]
          end else begin
            gate_cnt <= gate_cnt + 4'h1;
          end
        end
        CCSS_GATE_ON: begin
          if (gate_cnt == CCSS_GATE_LAST) begin
            state        <= CCSS_IDLE;
            cpu_clk_gate <= 1'b1;                                               // [RQ21]
          end else begin
            gate_cnt <= gate_cnt + 4'h1;
          end
        end
        default: state <= CCSS_IDLE; // Unused code falls back to idle
      endcase
    end
  end

  // Status bits follow the source once it drives the CPU again
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      subsystem_active_status <= 1'b0;
      main_source_status      <= 1'b0;
    end else if (state == CCSS_GATE_ON && gate_cnt == CCSS_GATE_LAST) begin
      subsystem_active_status <= cpu_src_sub;                                   // [RQ5] [RQ21]
      main_source_status      <= cpu_src_xtal;                                  // [RQ16] [RQ21]
    end
  end

  // ----------------------------------------------------------------
  // Oscillator controls
  // ----------------------------------------------------------------
  // Each crystal stop bit acts only on its own active source; ring stop acts only off the ring
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crystal_enable       <= 1'b1;
      ring_enable          <= 1'b1;
      feedback_resistor_on <= 1'b1;
    end else begin
      crystal_enable <= !((subsystem_active_status && crystal_stop_bit) ||     // [RQ2] [RQ10]
                          (!subsystem_active_status && !main_source_status &&
                           crystal_stop_from_ring));                           // [RQ9] [RQ18]
      ring_enable <= !(ring_stop_bit && ring_stoppable &&
                       (subsystem_active_status || main_source_status));       // [RQ12] [RQ13]
      feedback_resistor_on <= !feedback_resistor_off;                          // [RQ3]
    end
  end

  // Pulse whenever software writes a crystal stop bit as one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stab_clear <= 1'b0;
    end else begin
      stab_clear <= (wr_proc && sfr_wdata[CCSS_PROC_CRYSTAL_STOP]) ||
                    (wr_osc && sfr_wdata[CCSS_OSC_CRYSTAL_STOP]);              // [RQ20]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reset_clears_a: assert property (@(posedge clk)                              // [RQ1]
    !rst_n |=> (cpu_div_code == 3'h0 && !cpu_src_sub && crystal_enable))
    else $error("Reset did not select undivided main clock");

  gate_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)           // [RQ21]
    $fell(cpu_clk_gate) |-> !cpu_clk_gate [*5] ##1 !cpu_clk_gate [*5] ##1 cpu_clk_gate)
    else $error("Clock gate quiet period wrong");

  src_change_gated_a: assert property (@(posedge clk) disable iff (!rst_n)     // [RQ21]
    ($changed(cpu_div_code) || $changed(cpu_src_sub) || $changed(cpu_src_xtal))
      |-> !cpu_clk_gate)
    else $error("Source changed while clock passing");

  status_follows_a: assert property (@(posedge clk) disable iff (!rst_n)       // [RQ16]
    $rose(cpu_clk_gate) |-> main_source_status == cpu_src_xtal
                            && subsystem_active_status == cpu_src_sub)
    else $error("Status not updated when gate reopened");

  sub_status_read_a: assert property (@(posedge clk) disable iff (!rst_n)      // [RQ5]
    (sfr_re && sfr_addr == CCSS_ADDR_PROC_CLK)
      |=> sfr_rdata[CCSS_PROC_SUB_STATUS] == $past(subsystem_active_status)
          && !sfr_rdata[CCSS_PROC_FIXED_ZERO])
    else $error("Processor clock read wrong");

  crystal_sub_stop_a: assert property (@(posedge clk) disable iff (!rst_n)     // [RQ10]
    (subsystem_active_status && crystal_stop_from_ring && !crystal_stop_bit)
      |=> crystal_enable)
    else $error("Oscillator control stopped crystal on subsystem");

  crystal_ring_stop_a: assert property (@(posedge clk) disable iff (!rst_n)    // [RQ9]
    (!subsystem_active_status && !main_source_status && crystal_stop_bit
     && !crystal_stop_from_ring) |=> crystal_enable)
    else $error("Processor stop bit acted on ring clock");

  ring_stop_a: assert property (@(posedge clk) disable iff (!rst_n)            // [RQ13]
    (ring_stop_bit && ring_stoppable && main_source_status && !subsystem_active_status)
      |=> !ring_enable)
    else $error("Ring oscillator not stopped");

  ring_keep_a: assert property (@(posedge clk) disable iff (!rst_n)            // [RQ13]
    (!subsystem_active_status && !main_source_status) |=> ring_enable)
    else $error("Ring stopped while driving CPU");

  stab_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)           // [RQ20]
    ((wr_osc && sfr_wdata[CCSS_OSC_CRYSTAL_STOP]) ||
     (wr_proc && sfr_wdata[CCSS_PROC_CRYSTAL_STOP])) |=> stab_clear)
    else $error("Stabilisation clear pulse missing");

  feedback_off_a: assert property (@(posedge clk) disable iff (!rst_n)         // [RQ3]
    (wr_proc && sfr_wdata[CCSS_PROC_FEEDBACK_OFF]) |=> ##1 !feedback_resistor_on)
    else $error("Feedback resistor not disconnected");

endmodule

// >>> dv/tb_ccss_clock_select.sv
// Self-checking bench for the CPU clock source select block
`timescale 1ns/1ps
module tb_ccss_clock_select;
  import ccss_pkg::*;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  localparam logic [15:0] A_RING = CCSS_ADDR_RING_MODE; // Short aliases
  localparam logic [15:0] A_MAIN = CCSS_ADDR_MAIN_MODE;
  localparam logic [15:0] A_OSC  = CCSS_ADDR_MAIN_OSC;
  localparam logic [15:0] A_PROC = CCSS_ADDR_PROC_CLK;
  logic        clk, rst_n, sfr_we, sfr_re, strap;  // Bench-driven inputs
  logic [15:0] sfr_addr;                           // Register address
  logic [7:0]  sfr_wdata, sfr_rdata;               // Data both ways
  logic        crystal_enable, ring_enable, feedback_resistor_on;
  logic        cpu_clk_gate, cpu_src_sub, cpu_src_xtal, stab_clear;
  logic [2:0]  cpu_div_code;                       // Active divider
  logic        e_cr, e_rg, e_fb, e_sub, e_xt;      // Expected levels
  logic [2:0]  e_div;                              // Expected divider
  logic [31:0] seed, r;                            // Random state
  logic [7:0]  w;                                  // Value written
  int          n_errors, checked, s, k;            // Counters
  int          n_stab = 0;                         // Stabilisation clear pulses seen
  logic [15:0] addrs [5] = '{16'hFFA0, 16'hFFA1, 16'hFFA2, 16'hFFFB, 16'hFF00};
  logic [7:0]  bad [3] = '{8'h05, 8'h07, 8'h11};   // Prohibited settings

  // ----------------------------------------------------------------
  // Design and clock
  // ----------------------------------------------------------------
  ccss_clock_select i_ccss_clock_select (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .ring_stoppable_pin(strap),
    .sfr_rdata(sfr_rdata), .crystal_enable(crystal_enable), .ring_enable(ring_enable),
    .feedback_resistor_on(feedback_resistor_on), .cpu_clk_gate(cpu_clk_gate),
    .cpu_src_sub(cpu_src_sub), .cpu_src_xtal(cpu_src_xtal), .cpu_div_code(cpu_div_code),
    .stab_clear(stab_clear));
  // Free-running 25 MHz clock
  always #20 clk = ~clk;
  // Count stabilisation clear pulses
  always @(posedge clk) if (stab_clear === 1'b1) n_stab <= n_stab + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Read-back of processor clock control: status bit 5, bit 3 zero
  function automatic logic [7:0] proc_exp(input logic [7:0] v, input logic sub);
    return {v[7:6], sub, v[4], 1'b0, v[2:0]};
  endfunction
  // Expected output vector, gate open
  function automatic logic [15:0] exp_out();
    return {7'h00, e_cr, e_rg, e_fb, 1'b1, e_sub, e_xt, e_div};
  endfunction
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Compare all clock control outputs
  task automatic co();
    chk({7'h00, crystal_enable, ring_enable, feedback_resistor_on, cpu_clk_gate,
         cpu_src_sub, cpu_src_xtal, cpu_div_code}, exp_out());
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    cyc(1);
    sfr_we = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_re = 1'b1;
    cyc(1);
    sfr_re = 1'b0;
    cyc(1);
    chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask
  // Wait for a switch and measure the gated-off span
  task automatic wait_sw();
    int i;
    int lo;
    lo = 0;
    for (i = 0; i < 40 && cpu_clk_gate !== 1'b0; i++) cyc(1);
    for (i = 0; i < 40 && cpu_clk_gate === 1'b0; i++) begin
      cyc(1);
      lo++;
    end
    chk(16'(lo), 16'(2 * CCSS_GATE_CYCLES));
    if (lo == 0 || cpu_clk_gate !== 1'b1) print_verdict();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sfr_addr = 16'h0000;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    sfr_re = 1'b0;
    strap = 1'b1;
    seed = 32'h0000C31F;
    n_errors = 0;
    checked = 0;
    e_cr = 1'b1;
    e_rg = 1'b1;
    e_fb = 1'b1;
    e_sub = 1'b0;
    e_xt = 1'b0;
    e_div = 3'h0;
    cyc(8);
    rst_n = 1;
    co();
    foreach (addrs[j]) rd(addrs[j], 8'h00);
    wr(A_PROC, 8'h20);
    rd(A_PROC, 8'h00);
    wr(A_PROC, 8'h04);
    wait_sw();
    e_div = 3'h4;
    co();
    for (k = 0; k < 6; k++) begin
      r = xs();
      w = {1'b0, r[8], 3'b000, 3'(r % 5)};
      wr(A_PROC, w);
      if (w[2:0] != e_div) wait_sw();
      e_div = w[2:0];
      e_fb = ~w[6];
      cyc(2);
      co();
      rd(A_PROC, proc_exp(w, 1'b0));
    end
    foreach (bad[j]) begin
      wr(A_PROC, bad[j]);
      e_fb = 1;
      cyc(14);
      co();
      rd(A_PROC, proc_exp(bad[j], 1'b0));
    end
    wr(A_PROC, 8'h00);
    if (e_div != 3'h0) wait_sw();
    e_div = 3'h0;
    wr(A_MAIN, 8'h01);
    wait_sw();
    e_xt = 1;
    co();
    rd(A_MAIN, 8'h03);
    wr(A_RING, 8'h01);
    cyc(3);
    e_rg = 0;
    co();
    strap = 0;
    cyc(5);
    e_rg = 1;
    co();
    wr(A_RING, 8'h00);
    strap = 1;
    s = n_stab;
    wr(A_PROC, 8'h80);
    cyc(3);
    co();
    chk(16'(n_stab - s), 16'h0001);
    wr(A_PROC, 8'h10);
    wait_sw();
    e_sub = 1;
    co();
    rd(A_PROC, 8'h30);
    wr(A_RING, 8'h01);
    cyc(3);
    e_rg = 0;
    co();
    wr(A_RING, 8'h00);
    e_rg = 1;
    s = n_stab;
    wr(A_OSC, 8'h80);
    cyc(3);
    co();
    chk(16'(n_stab - s), 16'h0001);
    wr(A_OSC, 8'h00);
    wr(A_PROC, 8'h90);
    cyc(3);
    e_cr = 0;
    co();
    wr(A_PROC, 8'h10);
    cyc(3);
    e_cr = 1;
    co();
    wr(A_PROC, 8'h00);
    wait_sw();
    e_sub = 0;
    co();
    wr(A_MAIN, 8'h00);
    wait_sw();
    e_xt = 0;
    co();
    rd(A_MAIN, 8'h00);
    // Ring stop written while on ring clock: must be ignored
    wr(A_RING, 8'h01);
    cyc(3);
    co();
    wr(A_RING, 8'h00);
    wr(A_OSC, 8'h80);
    cyc(3);
    e_cr = 0;
    co();
    wr(A_OSC, 8'h00);
    wr(A_PROC, 8'h80);
    cyc(3);
    e_cr = 1;
    co();
    wr(A_PROC, 8'h40);
    rst_n = 0;
    cyc(3);
    rst_n = 1;
    co();
    rd(A_PROC, 8'h00);
    print_verdict();
  end
endmodule
